// ### dv/count_src_model.sv
// count clock source model feeding the timer candidate inputs
`timescale 1ns/1ps
module count_src_model (
  input wire logic clk_i,
  input wire logic en_i,
  output logic [7:0] src_o
);
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      src_o <= ~src_o;
    end else begin
      src_o <= 8'h00;
    end
  end
endmodule

// ### dv/tb.sv
// self-checking bench for the 8/16-bit timer
`timescale 1ns/1ps
module tb;
  import timer_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [7:0] count_src_i;
  logic sleep_i = 1'b0;
  logic src_en = 1'b0;
  logic match_pulse_out_o, timer_out_o, timer_irq_flag_o;
  int failures = 0;
  int compares = 0;
  logic [7:0] rd;
  eight_sixteen_bit_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .count_src_i(count_src_i), .sleep_i(sleep_i),
    .match_pulse_out_o(match_pulse_out_o), .timer_out_o(timer_out_o),
    .timer_irq_flag_o(timer_irq_flag_o));
  count_src_model i_src (.clk_i(clk_i), .en_i(src_en), .src_o(count_src_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic conclude();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      failures++;
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 50) begin
        failures++;
        conclude();
      end
      @(posedge clk_i);
    end
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    cycles(6);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_reset();
    bus(0, ADDR_LOW, 8'h00);
    check("low rst", rd, 8'h00);
    bus(0, ADDR_HIGH, 8'h00);
    check("high rst", rd, 8'hFF);
    bus(0, 5'h14, 8'h00);
    check("unmapped", rd, 8'h00);
    bus(1, ADDR_CTRL0, 8'h3F);
    bus(0, ADDR_CTRL0, 8'h00);
    check("ctrl0 back", rd, 8'h1F);
    bus(1, ADDR_CTRL1, 8'hA7);
    bus(0, ADDR_CTRL1, 8'h00);
    check("ctrl1 back", rd, 8'hA7);
    bus(0, ADDR_STAT, 8'h00);
    check("stat rst", rd, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_wide_rw();
    bus(1, ADDR_CTRL0, 8'h10);
    bus(1, ADDR_HIGH, 8'h12);
    bus(1, ADDR_LOW, 8'h34);
    bus(1, ADDR_HIGH, 8'h56);
    bus(0, ADDR_LOW, 8'h00);
    check("wide low", rd, 8'h34);
    bus(0, ADDR_HIGH, 8'h00);
    check("wide snapshot", rd, 8'h12);
    $display("test wide rw done");
  endtask
  task automatic t_rollover();
    int n;
    bus(1, ADDR_HIGH, 8'hFF);
    bus(1, ADDR_LOW, 8'hFE);
    bus(1, ADDR_CTRL1, 8'h40);
    bus(1, ADDR_CTRL0, 8'h90);
    n = 0;
    while (timer_irq_flag_o !== 1'b1 && n < 60) begin
      n++;
      @(posedge clk_i);
    end
    check("roll flag", timer_irq_flag_o, 1'b1);
    check("roll out", timer_out_o, 1'b1);
    bus(0, ADDR_STAT, 8'h00);
    check("stat flag", rd, 8'h01);
    bus(1, ADDR_CTRL0, 8'h10);
    bus(0, ADDR_LOW, 8'h00);
    bus(0, ADDR_HIGH, 8'h00);
    check("roll high", rd, 8'h00);
    bus(1, ADDR_STAT, 8'h01);
    check("flag clr", timer_irq_flag_o, 1'b0);
    $display("test rollover done");
  endtask
  task automatic t_prescale();
    bus(1, ADDR_HIGH, 8'h00);
    bus(1, ADDR_LOW, 8'h00);
    bus(1, ADDR_CTRL1, 8'h43);
    bus(1, ADDR_CTRL0, 8'h90);
    cycles(80);
    bus(1, ADDR_CTRL0, 8'h10);
    bus(0, ADDR_LOW, 8'h00);
    check("prescale 1:8", rd, 8'd10);
    $display("test prescale done");
  endtask
  task automatic t_count_ext(input logic [7:0] c1, input logic slp, input logic [7:0] exp);
    bus(1, ADDR_LOW, 8'h00);
    bus(1, ADDR_CTRL1, c1);
    bus(1, ADDR_CTRL0, 8'h90);
    sleep_i <= slp;
    src_en <= 1'b1;
    cycles(40);
    src_en <= 1'b0;
    cycles(6);
    sleep_i <= 1'b0;
    bus(1, ADDR_CTRL0, 8'h10);
    bus(0, ADDR_LOW, 8'h00);
    check("ext count", rd, exp);
    $display("test external count done");
  endtask
  task automatic t_period_post();
    int n;
    int pulses;
    int toggles;
    logic prev_m;
    logic prev_t;
    do_reset();
    bus(1, ADDR_HIGH, 8'h03);
    bus(1, ADDR_CTRL1, 8'h40);
    bus(1, ADDR_CTRL0, 8'h81);
    n = 0;
    while (timer_irq_flag_o !== 1'b1 && n < 700) begin
      n++;
      @(posedge clk_i);
    end
    check("post flag", timer_irq_flag_o, 1'b1);
    cycles(20);
    pulses = 0;
    toggles = 0;
    prev_m = match_pulse_out_o;
    prev_t = timer_out_o;
    repeat (40) begin
      @(posedge clk_i);
      if (match_pulse_out_o === 1'b1 && prev_m === 1'b0) pulses++;
      if (timer_out_o !== prev_t) toggles++;
      prev_m = match_pulse_out_o;
      prev_t = timer_out_o;
    end
    check("match pulses", pulses, 5);
    check("out toggles", toggles, 5);
    $display("test period postscale done");
  endtask
  initial begin
    do_reset();
    t_reset();
    t_wide_rw();
    t_rollover();
    t_prescale();
    // external source bit 0, counter mode
    t_count_ext(8'h00, 1'b0, 8'd20);
    t_count_ext(8'h00, 1'b1, 8'd0);
    t_count_ext(8'h10, 1'b1, 8'd20);
    t_period_post();
    conclude();
  end
endmodule

// ### src/eight_sixteen_bit_timer.sv
// 8/16-bit timer/counter with prescaler, postscaler and avalon slave
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module eight_sixteen_bit_timer
  import timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [7:0] count_src_i,
  input wire logic sleep_i,
  output logic match_pulse_out_o,
  output logic timer_out_o,
  output logic timer_irq_flag_o
);
  scale_if pre_if ();
  scale_if post_if ();

  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] low_q;
  logic [7:0] high_q;
  logic [7:0] hidden_q;
  logic [7:0] period_q;
  logic enable_q;
  logic wide_q;
  logic [3:0] post_sel_q;
  logic [2:0] src_sel_q;
  logic async_q;
  logic [3:0] pre_sel_q;
  logic src_prev_q;
  logic match_q;
  logic tout_q;
  logic flag_q;
  logic [7:0] wd;
  logic commit_wr;
  logic wr_low;
  logic wr_high;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_stat;
  logic rd_take;
  logic rd_low;
  logic src_lvl;
  logic src_edge;
  logic running;
  logic tick;
  logic at_period;
  logic at_max;
  logic event_p;
  logic [7:0] ctrl0_view;
  logic [7:0] ctrl1_view;

  // bus decode; a write takes effect at the edge where waitrequest is low
  assign wd = avs_writedata_i[7:0];
  assign commit_wr = avs_write_i && !wait_q && avs_byteenable_i[0];
  assign wr_low = commit_wr && (avs_address_i == ADDR_LOW);
  assign wr_high = commit_wr && (avs_address_i == ADDR_HIGH);
  assign wr_ctrl0 = commit_wr && (avs_address_i == ADDR_CTRL0);
  assign wr_ctrl1 = commit_wr && (avs_address_i == ADDR_CTRL1);
  assign wr_stat = commit_wr && (avs_address_i == ADDR_STAT);
  assign rd_take = avs_read_i && wait_q;
  assign rd_low = rd_take && (avs_address_i == ADDR_LOW);

  assign ctrl0_view = {enable_q, 1'b0, tout_q, wide_q, post_sel_q};
  assign ctrl1_view = {src_sel_q, async_q, pre_sel_q};

  // one wait state on every access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // read data captured as the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else if (rd_take) begin
      case (avs_address_i)
        ADDR_LOW: rdata_q <= {24'h000000, low_q};
        ADDR_HIGH: rdata_q <= {24'h000000, high_q};
        ADDR_CTRL0: rdata_q <= {24'h000000, ctrl0_view};
        ADDR_CTRL1: rdata_q <= {24'h000000, ctrl1_view};
        ADDR_STAT: rdata_q <= {31'h00000000, flag_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= 1'b0;
      wide_q <= 1'b0;
      post_sel_q <= SCALE_RST;
    end else if (wr_ctrl0) begin
      enable_q <= wd[CTRL0_EN_BIT];
      wide_q <= wd[CTRL0_WIDE_BIT];
      post_sel_q <= wd[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_sel_q <= SRC_RST;
      async_q <= 1'b0;
      pre_sel_q <= SCALE_RST;
    end else if (wr_ctrl1) begin
      src_sel_q <= wd[CTRL1_SRC_LSB+2:CTRL1_SRC_LSB];
      async_q <= wd[CTRL1_ASYNC_BIT];
      pre_sel_q <= wd[3:0];
    end
  end

  // source mux; instruction clock ticks every cycle
  assign src_lvl = count_src_i[src_sel_q];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
    end
  end

  // rising edge of the counter input
  assign src_edge = (src_sel_q == SRC_INSTR) ? 1'b1 : (src_lvl && !src_prev_q);

  // sync counting sampled on the instruction clock
  assign running = enable_q && (async_q || !sleep_i);

  assign pre_if.in_pulse = src_edge && running;
  assign pre_if.sel = pre_sel_q;
  // low or control writes clear the scalers
  assign pre_if.clr = wr_low || wr_ctrl0 || wr_ctrl1;
  assign tick = pre_if.out_pulse;

  prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sc(pre_if.unit)
  );

  assign at_period = (low_q == period_q);
  assign at_max = (hidden_q == 8'hFF) && (low_q == 8'hFF);
  assign event_p = tick && !wr_low && (wide_q ? at_max : at_period);

  // events divided by postscale plus one
  assign post_if.in_pulse = event_p;
  assign post_if.sel = post_sel_q;
  assign post_if.clr = wr_low || wr_ctrl0 || wr_ctrl1;

  postscaler u_post (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sc(post_if.unit)
  );

  // count and hidden high byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_q <= LOW_RST;
      hidden_q <= HIDDEN_RST;
      period_q <= HIGH_RST;
    end else if (wr_low) begin
      low_q <= wd;
      if (wide_q) begin
        hidden_q <= high_q;
      end
    end else if (tick) begin
      if (wide_q) begin
        {hidden_q, low_q} <= {hidden_q, low_q} + 16'h0001;
      end else if (at_period) begin
        low_q <= 8'h00;
        period_q <= high_q;
      end else begin
        low_q <= low_q + 8'h01;
      end
    end
  end

  // high buffer / period register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_q <= HIGH_RST;
    end else if (wr_high) begin
      high_q <= wd;
    end else if (rd_low && wide_q) begin
      high_q <= hidden_q;
    end
  end

  // match output held for one prescaled period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_q <= 1'b0;
    end else if (post_if.out_pulse) begin
      match_q <= 1'b1;
    end else if (tick) begin
      match_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tout_q <= 1'b0;
    end else if (post_if.out_pulse) begin
      tout_q <= !tout_q;
    end
  end

  // sticky flag, write one clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (post_if.out_pulse) begin
      flag_q <= 1'b1;
    end else if (wr_stat && wd[STAT_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign match_pulse_out_o = match_q;
  assign timer_out_o = tout_q;
  assign timer_irq_flag_o = flag_q;

  sequence s_taken;
    (avs_read_i || avs_write_i) && wait_q;
  endsequence

  sequence s_answer;
    !wait_q ##1 wait_q;
  endsequence

  chk_bus_answer_shape: assert property (@(posedge clk_i) disable iff (rst_i)
    s_taken |=> s_answer)
    else $error("bus answer not one wait state");

  chk_reset_values: assert property (@(posedge clk_i)
    rst_i |=> (low_q == LOW_RST) && (high_q == HIGH_RST))
    else $error("reset values wrong");

  chk_low_read_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_low && wide_q |=> high_q == $past(hidden_q))
    else $error("high buffer not loaded on low read");

  chk_low_write_load: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_low && wide_q |=> (hidden_q == $past(high_q)) && (low_q == $past(wd)))
    else $error("16-bit write not applied");

  chk_match_clear_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && !wide_q && !wr_low && at_period |=>
      (low_q == 8'h00) && (period_q == $past(high_q)))
    else $error("8-bit match did not clear and reload");

  chk_rollover_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && wide_q && !wr_low && at_max |-> event_p ##1 (low_q == 8'h00 && hidden_q == 8'h00))
    else $error("16-bit rollover wrong");

  chk_carry_high: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && wide_q && !wr_low && low_q == 8'hFF |=> hidden_q == $past(hidden_q) + 8'h01)
    else $error("carry not applied to hidden byte");

  chk_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    post_if.out_pulse |=> flag_q && match_q)
    else $error("flag or match not raised");

  chk_output_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    post_if.out_pulse |=> tout_q != $past(tout_q))
    else $error("timer output did not toggle");

  chk_sleep_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_i && !async_q |-> !tick)
    else $error("sync counter advanced in sleep");
endmodule

// ### src/postscaler.sv
// event divider, 1:1 to 1:16
`timescale 1ns/1ps
module postscaler
  import timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  scale_if.unit sc
);
  logic [POST_W-1:0] cnt_q;

  assign sc.out_pulse = sc.in_pulse && (cnt_q == sc.sel);

  always_ff @(posedge clk_i) begin
    if (rst_i || sc.clr) begin
      cnt_q <= '0;
    end else if (sc.out_pulse) begin
      cnt_q <= '0;
    end else if (sc.in_pulse) begin
      cnt_q <= cnt_q + POST_W'(1);
    end
  end
endmodule

// ### src/prescaler.sv
// power-of-two prescaler, 1:1 to 1:32768
`timescale 1ns/1ps
module prescaler
  import timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  scale_if.unit sc
);
  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] mask;

  always_comb begin
    mask = PRE_W'((16'h0001 << sc.sel) - 16'h0001);
  end

  assign sc.out_pulse = sc.in_pulse && ((cnt_q & mask) == mask);

  always_ff @(posedge clk_i) begin
    if (rst_i || sc.clr) begin
      cnt_q <= '0;
    end else if (sc.in_pulse) begin
      cnt_q <= cnt_q + PRE_W'(1);
    end
  end
endmodule

// ### src/scale_if.sv
// link between the timer core and a prescaler or postscaler
`timescale 1ns/1ps
interface scale_if;
  logic clr;
  logic in_pulse;
  logic [3:0] sel;
  logic out_pulse;
  modport ctrl (output clr, output in_pulse, output sel, input out_pulse);
  modport unit (input clr, input in_pulse, input sel, output out_pulse);
endinterface

// ### src/timer_pkg.sv
// constants shared by the timer block
package timer_pkg;
  localparam logic [4:0] ADDR_LOW = 5'h00;
  localparam logic [4:0] ADDR_HIGH = 5'h04;
  localparam logic [4:0] ADDR_CTRL0 = 5'h08;
  localparam logic [4:0] ADDR_CTRL1 = 5'h0C;
  localparam logic [4:0] ADDR_STAT = 5'h10;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] HIGH_RST = 8'hFF;
  localparam logic [7:0] HIDDEN_RST = 8'h00;
  localparam logic [3:0] SCALE_RST = 4'h0;
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic [2:0] SRC_INSTR = 3'h2;
  localparam int CTRL0_EN_BIT = 7;
  localparam int CTRL0_OUT_BIT = 5;
  localparam int CTRL0_WIDE_BIT = 4;
  localparam int CTRL1_SRC_LSB = 5;
  localparam int CTRL1_ASYNC_BIT = 4;
  localparam int STAT_FLAG_BIT = 0;
  localparam int PRE_W = 15;
  localparam int POST_W = 4;
endpackage
